// File: logic/fault_countdown_counter.sv
// hidden error generation counter with arm load and loop reload
`timescale 1ns/10ps
`default_nettype none
module fault_countdown_counter
   import fault_inject_pkg::*;
#(
   parameter int CNT_W = 32
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // control
   input wire logic load,
   input wire logic [CNT_W-1:0] load_value,
   input wire logic arm,
   input wire logic restart,
   input wire logic tick,
   // result
   output logic zero_pulse,
   output logic running
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic zero_q;
   wire step = arm && (cnt_q != '0) && tick;
   wire hit = step && (cnt_q == CNT_W'(1));

   // next count: arming write, then step, reload or stop at zero
   assign cnt_d = load ? load_value :
                  (hit && restart) ? load_value :
                  step ? cnt_q - CNT_W'(1) : cnt_q;

   // counter state; value never leaves this module
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         cnt_q <= CNT_W'(CNT_RESET);
         zero_q <= 1'b0;
      end
      else if (ce)
      begin
         cnt_q <= cnt_d;
         zero_q <= hit;
      end
   end

   assign zero_pulse = zero_q;
   assign running = arm && (cnt_q != '0);

endmodule
`default_nettype wire

// File: logic/fault_inject_pkg.sv
// shared constants, field positions and carriers of the fault injection block
package fault_inject_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int MM_ADDR_W = 16;
   localparam logic [MM_ADDR_W-1:0] CTL_BASE = 16'h0808;
   localparam logic [MM_ADDR_W-1:0] DOWN_BASE = 16'h0810;
   localparam logic [MM_ADDR_W-1:0] REC_STRIDE = 16'h0040;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int ARM_BIT = 31;
   localparam int LOOP_BIT = 30;
   localparam int MSV_BIT = 12;
   localparam int ADV_BIT = 11;
   localparam int PSN_BIT = 10;
   localparam int RPT_BIT = 9;
   localparam int CRIT_BIT = 8;
   localparam int CORR_HI = 7;
   localparam int CORR_LO = 6;
   localparam int POSTPONED_BIT = 5;
   localparam int LATENT_BIT = 4;
   localparam int SIGNALED_BIT = 3;
   localparam int UNRECOV_BIT = 2;
   localparam int UNCONT_BIT = 1;
   localparam int OVF_BIT = 0;
   // bits that can hold state at all; 29:13 and 63:32 are reserved
   localparam logic [31:0] CTL_IMPL_MASK = 32'hC000_1FFF;

   // ----------------------------------------------------------------
   // values after cold reset
   // ----------------------------------------------------------------
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] DOWN_RESET = 32'h0000_0000;
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // corrected kind encodings: control field and recorded status code
   // ----------------------------------------------------------------
   localparam logic [1:0] CORR_NONE = 2'h0;
   localparam logic [1:0] CORR_GENERIC = 2'h1;
   localparam logic [1:0] CORR_TRANSIENT = 2'h2;
   localparam logic [1:0] CORR_PERSIST = 2'h3;
   localparam logic [1:0] CODE_GENERIC = 2'h2;
   localparam logic [1:0] CODE_TRANSIENT = 2'h1;
   localparam logic [1:0] CODE_PERSIST = 2'h3;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SR_SELECT, SR_CONTROL, SR_COUNTDOWN} sr_target_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [MM_ADDR_W-1:0] addr;
      logic [63:0] wdata;
   } mm_req_t;

   typedef struct packed {
      logic valid;
      logic write;
      sr_target_t target;
      logic [63:0] wdata;
   } sr_req_t;

   typedef struct packed {
      logic [1:0] corr_code;
      logic postponed;
      logic latent;
      logic signaled;
      logic unrecoverable;
      logic uncontainable;
      logic msv;
      logic adv;
      logic psn;
      logic rpt;
      logic crit;
      logic of;
   } inject_evt_t;

endpackage

// File: logic/fault_injection_countdown.sv
// pseudo-fault injection registers, countdown and error raising for one node
// ----------------------------------------------------------------
// How it works
// - writing arm as one loads the hidden counter from the countdown value
// - armed and nonzero, the counter drops by one per tick
// - at zero exactly one enabled error type is raised
// - loop mode reloads the counter at zero; otherwise it stops
// - arm clear means no counting and no errors
// - cold reset clears arm; recovery reset keeps it
// - other fields are free at cold reset and kept at recovery reset; here cold reset clears them to zero
// - the running count is never readable
// - reserved bits read zero and ignore writes
// - injected record takes the misc-valid flag; may read as one
// - injected record takes the address-valid flag; may read as one
// - poison, reported and critical flags are forced from control bits
// - overflow flag is forced from control bit zero
// - corrected kind field selects none, generic, transient or persistent
// - corrected kinds record as codes two, one and three
// - each uncorrected or postponed enable allows that type when set
// - injection does not depend on whether data is consumed
// - unsupported control bits read zero and ignore writes
// - registers exist only for implemented first record with injection support
// - memory-mapped control at 0x808 and countdown at 0x810 plus 64 per record
// - system aliases reach the record chosen by record_select
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module fault_injection_countdown
   import fault_inject_pkg::*;
#(
   parameter int REC_INDEX = 0,
   parameter bit RECORD_IMPL = 1'b1,
   parameter logic [1:0] INJ_SUPPORT = 2'h1,
   parameter bit FIRST_OF_NODE = 1'b1,
   parameter logic [31:0] CTL_SUPPORT = 32'hC000_1FFF,
   parameter bit MV_ALWAYS = 1'b0,
   parameter bit AV_ALWAYS = 1'b0,
   parameter int TICK_DIV = 1,
   parameter int SEL_W = 16
)
(
   // clock, resets and enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic recov_rst,
   input wire logic ce,
   // memory-mapped register access
   input wire mm_req_t mm_req,
   output logic mm_ready,
   output logic [63:0] mm_rdata,
   // system register alias access
   input wire sr_req_t sr_req,
   output logic sr_ready,
   output logic [63:0] sr_rdata,
   // injected error towards the error record
   output logic inject_valid,
   output inject_evt_t inject_evt,
   output logic countdown_running
);

   // ----------------------------------------------------------------
   // presence and address decode
   // ----------------------------------------------------------------

   // byte address of a register of this record
   function automatic logic [MM_ADDR_W-1:0] rec_addr(input logic [MM_ADDR_W-1:0] base);
      logic [31:0] full;
      full = 32'(base) + 32'(REC_STRIDE) * 32'(REC_INDEX);
      return full[MM_ADDR_W-1:0];
   endfunction

   localparam logic [MM_ADDR_W-1:0] CTL_ADDR = rec_addr(CTL_BASE);
   localparam logic [MM_ADDR_W-1:0] DOWN_ADDR = rec_addr(DOWN_BASE);
   localparam bit PRESENT = RECORD_IMPL && (INJ_SUPPORT != 2'h0) && FIRST_OF_NODE;
   // stored bits: implemented and supported only
   localparam logic [31:0] CTL_KEEP = CTL_IMPL_MASK & CTL_SUPPORT;
   // bits that read as one regardless of the stored value
   localparam logic [31:0] CTL_RAO = {19'h0, MV_ALWAYS, AV_ALWAYS, 11'h0};
   localparam int TICK_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [31:0] ctl_q;
   logic [31:0] ctl_d;
   logic [31:0] down_q;
   logic [31:0] down_d;
   logic [SEL_W-1:0] sel_q;
   logic [SEL_W-1:0] sel_d;
   logic [TICK_W-1:0] tick_q;
   logic mm_ready_q;
   logic [63:0] mm_rdata_q;
   logic sr_ready_q;
   logic [63:0] sr_rdata_q;
   logic inject_valid_q;
   inject_evt_t inject_evt_q;
   logic running_q;

   // ----------------------------------------------------------------
   // request decode for both access paths
   // ----------------------------------------------------------------

   // memory-mapped hits
   wire mm_hit_ctl = mm_req.valid && (mm_req.addr == CTL_ADDR);
   wire mm_hit_down = mm_req.valid && (mm_req.addr == DOWN_ADDR);
   wire mm_wr_ctl = PRESENT && mm_hit_ctl && mm_req.write;
   wire mm_wr_down = PRESENT && mm_hit_down && mm_req.write;

   // alias hits only when the selected record is this one
   wire sel_match = (sel_q == SEL_W'(REC_INDEX));
   wire sr_wr_sel = sr_req.valid && sr_req.write && (sr_req.target == SR_SELECT);
   wire sr_hit_ctl = sr_req.valid && (sr_req.target == SR_CONTROL) && sel_match;
   wire sr_hit_down = sr_req.valid && (sr_req.target == SR_COUNTDOWN) && sel_match;
   wire sr_wr_ctl = PRESENT && sr_hit_ctl && sr_req.write;
   wire sr_wr_down = PRESENT && sr_hit_down && sr_req.write;

   // merged writes; memory-mapped path wins a same-cycle collision
   wire ctl_wr = mm_wr_ctl || sr_wr_ctl;
   wire down_wr = mm_wr_down || sr_wr_down;
   wire [63:0] ctl_wdata = mm_wr_ctl ? mm_req.wdata : sr_req.wdata;
   wire [63:0] down_wdata = mm_wr_down ? mm_req.wdata : sr_req.wdata;

   // ----------------------------------------------------------------
   // register next values
   // ----------------------------------------------------------------

   // upper halves and reserved bits are dropped here
   assign ctl_d = ctl_wr ? (ctl_wdata[31:0] & CTL_KEEP) : ctl_q;
   assign down_d = down_wr ? down_wdata[31:0] : down_q;
   assign sel_d = sr_wr_sel ? sr_req.wdata[SEL_W-1:0] : sel_q;

   // arming write: any write with arm set reloads, even if already armed
   wire arm_load = ctl_wr && ctl_wdata[ARM_BIT] && CTL_KEEP[ARM_BIT];

   // countdown reload source is the value being written alongside, if any
   wire [31:0] load_value = down_wr ? down_d : down_q;

   // control as the rest of the node sees it
   wire [31:0] ctl_eff = (ctl_q & CTL_KEEP) | CTL_RAO;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------

   // only the stored fields are visible; the live count is not
   wire [63:0] ctl_rd = PRESENT ? {32'h0000_0000, ctl_eff} : 64'h0000_0000_0000_0000;
   wire [63:0] down_rd = PRESENT ? {32'h0000_0000, down_q} : 64'h0000_0000_0000_0000;
   wire [63:0] sel_rd = {{(64 - SEL_W){1'b0}}, sel_q};

   // memory-mapped read mux; unmapped offsets answer zero
   wire [63:0] mm_rd = mm_hit_ctl ? ctl_rd :
                       mm_hit_down ? down_rd : 64'h0000_0000_0000_0000;

   // alias read mux; a foreign selection answers zero
   wire [63:0] sr_rd = (sr_req.target == SR_SELECT) ? sel_rd :
                       sr_hit_ctl ? ctl_rd :
                       sr_hit_down ? down_rd : 64'h0000_0000_0000_0000;

   // ----------------------------------------------------------------
   // tick prescaler for the counter clock rate
   // ----------------------------------------------------------------
   wire tick = (tick_q == TICK_LAST);

   // divides sys_clk down to the counting rate
   always_ff @(posedge sys_clk)
   begin
      if (rst || recov_rst)
         tick_q <= '0;
      else if (ce)
         tick_q <= tick ? '0 : tick_q + TICK_W'(1);
   end

   // ----------------------------------------------------------------
   // hidden counter and error type choice
   // ----------------------------------------------------------------
   logic zero_pulse;
   logic cnt_running;
   inject_evt_t sel_evt;
   logic sel_any;

   // counter is 32 bits, loaded only by arming or loop reload
   fault_countdown_counter #(
      .CNT_W(32)
   ) u_counter (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .load(arm_load),
      .load_value(load_value),
      .arm(ctl_q[ARM_BIT]),
      .restart(ctl_eff[LOOP_BIT]),
      .tick(tick),
      .zero_pulse(zero_pulse),
      .running(cnt_running)
   );

   // one error type out of the enabled set
   fault_type_select u_select (
      .ctl(ctl_eff),
      .evt(sel_evt),
      .any(sel_any)
   );

   // raised regardless of later data use, and only while armed
   wire fire = zero_pulse && sel_any && ctl_q[ARM_BIT];

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------

   // cold reset clears everything; recovery reset leaves all fields
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ctl_q <= CTL_RESET;
         down_q <= DOWN_RESET;
         sel_q <= '0;
      end
      else if (ce)
      begin
         ctl_q <= ctl_d;
         down_q <= down_d;
         sel_q <= sel_d;
      end
   end

   // ----------------------------------------------------------------
   // access answers
   // ----------------------------------------------------------------

   // one-cycle acknowledge with registered read data
   always_ff @(posedge sys_clk)
   begin
      if (rst || recov_rst)
      begin
         mm_ready_q <= 1'b0;
         mm_rdata_q <= 64'h0000_0000_0000_0000;
         sr_ready_q <= 1'b0;
         sr_rdata_q <= 64'h0000_0000_0000_0000;
      end
      else if (ce)
      begin
         mm_ready_q <= mm_req.valid;
         mm_rdata_q <= (mm_req.valid && !mm_req.write) ? mm_rd : 64'h0000_0000_0000_0000;
         sr_ready_q <= sr_req.valid;
         sr_rdata_q <= (sr_req.valid && !sr_req.write) ? sr_rd : 64'h0000_0000_0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // injected error towards the record
   // ----------------------------------------------------------------

   // one-cycle event carrying type and forced status flags
   always_ff @(posedge sys_clk)
   begin
      if (rst || recov_rst)
      begin
         inject_valid_q <= 1'b0;
         inject_evt_q <= '0;
      end
      else if (ce)
      begin
         inject_valid_q <= fire;
         inject_evt_q <= fire ? sel_evt : '0;
      end
   end

   // live indication that a countdown is in progress, not its value
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         running_q <= 1'b0;
      else if (ce)
         running_q <= cnt_running;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign mm_ready = mm_ready_q;
   assign mm_rdata = mm_rdata_q;
   assign sr_ready = sr_ready_q;
   assign sr_rdata = sr_rdata_q;
   assign inject_valid = inject_valid_q;
   assign inject_evt = inject_evt_q;
   assign countdown_running = running_q;

endmodule
`default_nettype wire

// File: logic/fault_type_select.sv
// picks one enabled error type and builds the status flags to force
`timescale 1ns/10ps
`default_nettype none
module fault_type_select
   import fault_inject_pkg::*;
(
   // effective control word
   input wire logic [31:0] ctl,
   // selected error
   output inject_evt_t evt,
   output logic any
);

   // map control encoding of corrected kind onto the status code
   function automatic logic [1:0] corr_to_code(input logic [1:0] kind);
      logic [1:0] code;
      code = 2'h0;
      unique case (kind)
         CORR_GENERIC: code = CODE_GENERIC;
         CORR_TRANSIENT: code = CODE_TRANSIENT;
         CORR_PERSIST: code = CODE_PERSIST;
         CORR_NONE: code = 2'h0;
      endcase
      return code;
   endfunction

   // priority: most severe enabled type wins, only one is raised
   wire pick_unc = ctl[UNCONT_BIT];
   wire pick_uu = !pick_unc && ctl[UNRECOV_BIT];
   wire pick_sig = !pick_unc && !pick_uu && ctl[SIGNALED_BIT];
   wire pick_lat = !pick_unc && !pick_uu && !pick_sig && ctl[LATENT_BIT];
   wire pick_pp = !pick_unc && !pick_uu && !pick_sig && !pick_lat && ctl[POSTPONED_BIT];
   wire uncorr = ctl[UNCONT_BIT] | ctl[UNRECOV_BIT] | ctl[SIGNALED_BIT] | ctl[LATENT_BIT]
                 | ctl[POSTPONED_BIT];
   wire pick_ce = !uncorr && (ctl[CORR_HI:CORR_LO] != CORR_NONE);

   // outgoing event fields
   assign evt.corr_code = pick_ce ? corr_to_code(ctl[CORR_HI:CORR_LO]) : 2'h0;
   assign evt.uncontainable = pick_unc;
   assign evt.unrecoverable = pick_uu;
   assign evt.signaled = pick_sig;
   assign evt.latent = pick_lat;
   assign evt.postponed = pick_pp;
   assign evt.msv = ctl[MSV_BIT];
   assign evt.adv = ctl[ADV_BIT];
   assign evt.psn = ctl[PSN_BIT];
   assign evt.rpt = ctl[RPT_BIT];
   assign evt.crit = ctl[CRIT_BIT];
   assign evt.of = ctl[OVF_BIT];
   assign any = uncorr | pick_ce;

endmodule
`default_nettype wire

// File: verif/fault_injection_countdown_bench.sv
// self-checking bench of the fault injection block
`timescale 1ns/10ps
`default_nettype none
module fault_injection_countdown_bench;
   import fault_inject_pkg::*;
   localparam logic [15:0] CTL_A = CTL_BASE + REC_STRIDE;
   localparam logic [15:0] DOWN_A = DOWN_BASE + REC_STRIDE;
   logic sys_clk = 1'b0;
   logic ce = 1'b1;
   logic rst = 1'b1;
   logic recov_rst = 1'b0;
   mm_req_t mm_req;
   sr_req_t sr_req;
   logic mm_ready, sr_ready, inject_valid, countdown_running;
   logic [63:0] mm_rdata, sr_rdata, rd;
   inject_evt_t inject_evt, last_evt;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int n_inj = 0;
   int last_at = 0;
   int prev_at = 0;
   int t0, k;
   // control words per type (supported kinds only) and expected events
   logic [31:0] tab_ctl [9] = '{32'h0000_1020, 32'h0000_0810, 32'h0000_0208,
      32'h0000_0104, 32'h0000_0040, 32'h0000_0080, 32'h0000_00C0, 32'h0000_0006, '0};
   inject_evt_t tab_evt [9] = '{13'h0420, 13'h0210, 13'h0104, 13'h0082, 13'h1000,
      13'h0800, 13'h1800, 13'h0040, '0};

   always #2.5 sys_clk = ~sys_clk;

   fault_injection_countdown #(.REC_INDEX(1)) dut (.sys_clk(sys_clk), .rst(rst),
      .recov_rst(recov_rst), .ce(ce), .mm_req(mm_req), .mm_ready(mm_ready),
      .mm_rdata(mm_rdata), .sr_req(sr_req), .sr_ready(sr_ready), .sr_rdata(sr_rdata),
      .inject_valid(inject_valid), .inject_evt(inject_evt),
      .countdown_running(countdown_running));
   sw_reg_agent ag (.sys_clk(sys_clk), .mm_req(mm_req), .mm_ready(mm_ready),
      .mm_rdata(mm_rdata), .sr_req(sr_req), .sr_ready(sr_ready), .sr_rdata(sr_rdata));

   // ----------------------------------------------------------------
   // monitor and compares
   // ----------------------------------------------------------------
   // stamps every injection with its cycle
   always @(negedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (inject_valid === 1'b1)
      begin
         n_inj <= n_inj + 1;
         prev_at <= last_at;
         last_at <= cyc;
         last_evt <= inject_evt;
      end
   end

   task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_evt(input inject_evt_t got, input inject_evt_t exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t event %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_num(input int got, input int exp);
      total_checks++;
      if (got != exp)
      begin
         num_errors++;
         $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] addr, input logic [63:0] wd);
      ag.mm_rw(1'b1, addr, wd, rd);
   endtask

   task automatic rdchk(input logic [15:0] addr, input logic [63:0] exp);
      ag.mm_rw(1'b0, addr, '0, rd);
      check_word(rd, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic pulse_reset(input bit cold, input int n);
      @(negedge sys_clk);
      if (cold)
         rst = 1'b1;
      else
         recov_rst = 1'b1;
      idle(n);
      rst = 1'b0;
      recov_rst = 1'b0;
   endtask

   task automatic results();
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial
   begin
      pulse_reset(1'b1, 6);
      rdchk(CTL_A, '0);
      rdchk(DOWN_A, '0);
      // reserved bits and map
      wr(DOWN_A, 64'hFFFF_FFFF_0000_0006);
      rdchk(DOWN_A, 64'h0000_0000_0000_0006);
      wr(CTL_A, 64'hFFFF_FFFF_3FFF_E000);
      rdchk(CTL_A, '0);
      rdchk(CTL_BASE, '0);
      rdchk(16'h0818, '0);
      // arm, then rewrite the value alone while counting
      wr(CTL_A, 64'h0000_0000_8000_0503);
      t0 = cyc;
      wr(DOWN_A, 64'h0000_0000_0000_0028);
      idle(12);
      check_num(n_inj, 1);
      check_num(last_at - t0, 7);
      check_evt(last_evt, 13'h004B);
      rdchk(DOWN_A, 64'h0000_0000_0000_0028);
      // every type and the misc, address, reported and critical flags, one shot each
      wr(DOWN_A, 64'h0000_0000_0000_0003);
      for (int i = 0; i < 9; i++)
      begin
         k = n_inj;
         wr(CTL_A, {32'h0000_0000, 32'h8000_0000 | tab_ctl[i]});
         idle(10);
         check_num(n_inj - k, int'(tab_evt[i] != '0));
         if (tab_evt[i] != '0)
            check_evt(last_evt, tab_evt[i]);
      end
      // loop mode, then disarm
      wr(CTL_A, 64'h0000_0000_C000_0002);
      idle(12);
      check_num(last_at - prev_at, 3);
      wr(CTL_A, 64'h0000_0000_4000_0002);
      idle(1);
      k = n_inj;
      idle(10);
      check_num(n_inj - k, 0);
      // recovery reset keeps, cold reset clears
      wr(DOWN_A, '0);
      wr(CTL_A, 64'h0000_0000_C000_1FFF);
      pulse_reset(1'b0, 2);
      rdchk(CTL_A, 64'h0000_0000_C000_1FFF);
      rdchk(DOWN_A, '0);
      check_num(n_inj - k, 0);
      pulse_reset(1'b1, 2);
      rdchk(CTL_A, '0);
      // alias path: wrong record, then this record
      ag.sr_rw(1'b1, SR_SELECT, '0, rd);
      ag.sr_rw(1'b1, SR_CONTROL, 64'h0000_0000_8000_0008, rd);
      ag.sr_rw(1'b0, SR_CONTROL, '0, rd);
      check_word(rd, '0);
      rdchk(CTL_A, '0);
      ag.sr_rw(1'b1, SR_SELECT, 64'h0000_0000_0000_0001, rd);
      ag.sr_rw(1'b1, SR_COUNTDOWN, 64'h0000_0000_0000_0002, rd);
      k = n_inj;
      ag.sr_rw(1'b1, SR_CONTROL, 64'h0000_0000_8000_0008, rd);
      idle(8);
      check_num(n_inj - k, 1);
      check_evt(last_evt, 13'h0100);
      ag.sr_rw(1'b0, SR_COUNTDOWN, '0, rd);
      check_word(rd, 64'h0000_0000_0000_0002);
      // clock enable low freezes the running countdown
      ag.sr_rw(1'b1, SR_CONTROL, 64'h0000_0000_8000_0008, rd);
      k = n_inj;
      idle(1);
      ce = 1'b0;
      idle(20);
      check_num(n_inj - k, 0);
      check_word(countdown_running, 64'h0000_0000_0000_0001);
      ce = 1'b1;
      idle(8);
      check_num(n_inj - k, 1);
      results();
   end

   // watchdog well beyond the sequence length
   initial
   begin
      repeat (4000) @(posedge sys_clk);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire

// File: verif/fault_injection_countdown_properties.sv
// port-level checks of the fault injection block
`timescale 1ns/10ps
`default_nettype none
module fault_injection_countdown_properties
   import fault_inject_pkg::*;
#(
   parameter int REC_INDEX = 0
)
(
   // clock, resets and enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic recov_rst,
   input wire logic ce,
   // register paths
   input wire mm_req_t mm_req,
   input wire logic mm_ready,
   input wire logic [63:0] mm_rdata,
   input wire sr_req_t sr_req,
   input wire logic sr_ready,
   input wire logic [63:0] sr_rdata,
   // injected error
   input wire logic inject_valid,
   input wire inject_evt_t inject_evt,
   input wire logic countdown_running
);
   // ----------------------------------------------------------------
   // helper decode
   // ----------------------------------------------------------------
   localparam logic [15:0] CTL_ADDR = CTL_BASE + 16'(REC_INDEX * 64);
   // memory-mapped write that clears the arm bit
   wire logic disarm_wr = mm_req.valid && mm_req.write && (mm_req.addr == CTL_ADDR)
      && !mm_req.wdata[ARM_BIT];
   // one bit per error type that the event may carry
   wire logic [5:0] kinds = {inject_evt.corr_code != 2'h0, inject_evt.postponed,
      inject_evt.latent, inject_evt.signaled, inject_evt.unrecoverable,
      inject_evt.uncontainable};

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst || recov_rst);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_mm_answer_timing: assert property (1'b1 |=> mm_ready == $past(mm_req.valid && ce))
      else $error("memory-mapped answer not one cycle after request");
   chk_sr_answer_timing: assert property (1'b1 |=> sr_ready == $past(sr_req.valid && ce))
      else $error("alias answer not one cycle after request");
   chk_upper_half_zero: assert property (mm_rdata[63:32] == 32'h0000_0000
      && sr_rdata[63:32] == 32'h0000_0000)
      else $error("reserved upper read data not zero");
   chk_write_data_zero: assert property (mm_req.valid && mm_req.write |=> mm_rdata == '0)
      else $error("write answer carried data");
   chk_evt_idle_zero: assert property (!inject_valid |-> inject_evt == '0)
      else $error("event fields set without injection");
   chk_single_type: assert property (inject_valid |-> $onehot(kinds))
      else $error("injection did not carry exactly one type");
   chk_inject_needs_run: assert property (inject_valid |-> $past(countdown_running))
      else $error("injection without a running countdown");
   chk_disarm_silence: assert property (disarm_wr |=> ##1 !inject_valid [*2])
      else $error("injection after disarm");
   chk_cold_clear: assert property (@(posedge sys_clk) disable iff (recov_rst)
      rst |=> !countdown_running && !inject_valid)
      else $error("cold reset left countdown active");
endmodule

bind fault_injection_countdown fault_injection_countdown_properties #(.REC_INDEX(REC_INDEX))
   chk_i (.sys_clk(sys_clk), .rst(rst), .recov_rst(recov_rst), .ce(ce), .mm_req(mm_req),
   .mm_ready(mm_ready), .mm_rdata(mm_rdata), .sr_req(sr_req), .sr_ready(sr_ready),
   .sr_rdata(sr_rdata), .inject_valid(inject_valid), .inject_evt(inject_evt),
   .countdown_running(countdown_running));
`default_nettype wire

// File: verif/sw_reg_agent.sv
// software model reaching the injection registers over both paths
`timescale 1ns/10ps
`default_nettype none
module sw_reg_agent
   import fault_inject_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // memory-mapped path
   output var mm_req_t mm_req,
   input wire logic mm_ready,
   input wire logic [63:0] mm_rdata,
   // system register alias path
   output var sr_req_t sr_req,
   input wire logic sr_ready,
   input wire logic [63:0] sr_rdata
);
   // idle at time zero
   initial
   begin
      mm_req = '0;
      sr_req = '0;
   end

   // one memory-mapped access; released with inverted payload
   task automatic mm_rw(input logic wr, input logic [15:0] addr, input logic [63:0] wd,
      output logic [63:0] rd);
      int n;
      n = 0;
      @(negedge sys_clk);
      mm_req = '{valid: 1'b1, write: wr, addr: addr, wdata: wd};
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (mm_ready !== 1'b1 && n < 8);
      rd = mm_rdata;
      mm_req = '{valid: 1'b0, write: 1'b0, addr: ~addr, wdata: ~wd};
   endtask

   // one alias access; the record is chosen by a prior select write
   task automatic sr_rw(input logic wr, input sr_target_t tg, input logic [63:0] wd,
      output logic [63:0] rd);
      int n;
      n = 0;
      @(negedge sys_clk);
      sr_req = '{valid: 1'b1, write: wr, target: tg, wdata: wd};
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (sr_ready !== 1'b1 && n < 8);
      rd = sr_rdata;
      sr_req = '{valid: 1'b0, write: 1'b0, target: tg, wdata: ~wd};
   endtask
endmodule
`default_nettype wire
